// *** rtl/seq_pkg.sv ***
package seq_pkg;
    // ---------------------------------------------------------------
    // Timing and widths
    // ---------------------------------------------------------------
    localparam int CLK_MHZ           = 250;
    localparam int OC_LATCH_US       = 50;
    localparam int OC_LATCH_CYCLES   = OC_LATCH_US * CLK_MHZ;
    localparam int SS_STEP_CYCLES    = 64;
    localparam int CONFIG_CYCLES     = 256;
    localparam int DAC_W             = 8;
    localparam int ADC_W             = 8;
    localparam int TEMP_SAMPLE_CYCLES = 1024;
    localparam int FREQ_SEL_W        = 4;
    localparam int FREQ_CODES        = 16;
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    localparam logic [7:0] PLATFORM_MAX_CURRENT_OFS = 8'h21;
    localparam logic [7:0] OUTPUT_CURRENT_OFS       = 8'h15;
    localparam logic [7:0] TEMP_READING_OFS         = 8'h17;
    localparam logic [7:0] REG_RESET                = 8'h00;
    // Full-scale converter code equals 2.5 V
    localparam logic [7:0] ADC_FULL_SCALE           = 8'hff;
    // ---------------------------------------------------------------
    // Drive pin levels and sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        DRV_FLOAT = 2'h0,
        DRV_LOW   = 2'h1,
        DRV_HIGH  = 2'h2,
        DRV_MID   = 2'h3
    } drive_e;
    typedef enum logic [5:0] {
        ST_CONFIG  = 6'h01,
        ST_WAIT_EN = 6'h02,
        ST_MID     = 6'h04,
        ST_RAMP    = 6'h08,
        ST_RUN     = 6'h10,
        ST_FAULT   = 6'h20
    } seq_state_e;
endpackage

// *** rtl/multiphase_startup_fault_sequencer.sv ***
`timescale 1ns/10ps
// How it works
// [R1] Core phase count from sense straps
// [R2] Aux phase off when its strap high
// [R3] Over-limit starts 50 us latch counter
// [R4] 150 percent load shuts down at once
// [R5] Shutdown holds until supply or enable cycles
// [R6] Counter clears if over-limit goes away
// [R7] Max current code one amp per step
// [R8] Max current captured when enabled
// [R9] Max current register read only afterward
// [R10] Output current digitised, full scale 2.5V
// [R11] Temperature input sampled periodically
// [R12] Frequency code read from phase 4 strap
// [R13] Equal phase spacing, aux between 1 and 2; code uses a half-period step for three phases and sets no aux position
// [R14] Feed-forward lockout only while enabled
// [R15] No startup while driver handshake low
// [R16] Soft start DAC counts up to target
// [R17] Outputs float during configuration
// [R18] Mid level then driver on asserted
// [R19] Phase leaves mid on first pulse
// [R20] Disable returns outputs to mid
// [R21] Overvoltage drops ready, ramps to zero
// [R22] Overvoltage: high sides off, low on
// [R23] Overvoltage latched until supply/enable cycles
module multiphase_startup_fault_sequencer
    import seq_pkg::*;
#(
    parameter int OC_CYCLES = seq_pkg::OC_LATCH_CYCLES
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    // Supply and enable
    input  wire logic                   supply_ok,
    input  wire logic                   enable,
    input  wire logic                   input_feedforward_ok,
    // Straps
    input  wire logic                   phase2_sense_strap,
    input  wire logic                   phase3_sense_strap,
    input  wire logic                   phase4_sense_strap,
    input  wire logic                   aux_phase1_sense_strap,
    input  wire logic                   aux_phase2_sense_strap,
    input  wire logic [FREQ_SEL_W-1:0]  phase4_freq_strap,
    // Protection comparators
    input  wire logic                   over_limit,
    input  wire logic                   over_limit_150,
    input  wire logic                   over_voltage,
    // Converter samples
    input  wire logic [ADC_W-1:0]       max_current_program_input,
    input  wire logic [ADC_W-1:0]       output_current_sample,
    input  wire logic [ADC_W-1:0]       temperature_sense_input,
    input  wire logic [DAC_W-1:0]       target_code,
    // Per-phase PWM requests from modulators
    input  wire logic [3:0]             core_pwm_req,
    input  wire logic [1:0]             aux_pwm_req,
    // Driver handshake
    input  wire logic                   driver_on_handshake_in,
    output logic                        driver_on_handshake,
    // Phase drive outputs
    output drive_e                      phase1_drive_out,
    output drive_e                      phase2_drive_out,
    output drive_e                      phase3_drive_out,
    output drive_e                      phase4_drive_out,
    output drive_e                      aux_phase1_drive_out,
    output drive_e                      aux_phase2_drive_out,
    // Status
    output logic [2:0]                  core_phase_count,
    output logic [FREQ_SEL_W-1:0]       freq_select,
    output logic [1:0]                  core_ramp_step,
    output logic                        regulator_ready,
    output logic [DAC_W-1:0]            dac_code,
    output logic                        fault_latched,
    // Register read port
    input  wire logic [7:0]             reg_addr,
    output logic [7:0]                  reg_rdata
);
    import seq_pkg::*;

    seq_state_e              state_reg;
    logic [3:0]              core_en;
    logic [1:0]              aux_en;
    logic [31:0]             oc_cnt_reg;
    logic [15:0]             cfg_cnt_reg;
    logic [15:0]             step_cnt_reg;
    logic [15:0]             temp_cnt_reg;
    logic [7:0]              max_current_reg;
    logic [7:0]              iout_reg;
    logic [7:0]              temp_reg;
    logic                    captured_reg;
    logic                    enable_d_reg;
    logic                    supply_d_reg;
    logic [3:0]              core_fired_reg;
    logic [1:0]              aux_fired_reg;
    logic                    ov_reg;
    logic                    oc_trip;
    logic                    rearm;
    logic                    run_en;

    // ---------------------------------------------------------------
    // Phase straps
    // ---------------------------------------------------------------
    always_comb begin
        // Strap combinations outside the documented set keep all four, except phase 3 with phase 4 strapped, which gives three
        if (phase2_sense_strap && phase3_sense_strap && phase4_sense_strap) begin
            core_en = 4'h1; // [R1]
        end else if (phase2_sense_strap && phase4_sense_strap) begin
            core_en = 4'h5; // [R1]
        end else if (phase4_sense_strap) begin
            core_en = 4'h7; // [R1]
        end else begin
            core_en = 4'hf; // [R1]
        end
        aux_en = {~aux_phase2_sense_strap, ~aux_phase1_sense_strap}; // [R2]
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_phase_count <= 3'h0;
            freq_select      <= '0;
        end else if (state_reg == ST_CONFIG) begin
            core_phase_count <= 3'(core_en[0] + core_en[1] + core_en[2] + core_en[3]); // [R1]
            freq_select      <= phase4_freq_strap; // [R12]
        end
    end

    // Core ramps at quarter-period offsets with four phases, half-period otherwise
    assign core_ramp_step = (core_phase_count == 3'h4) ? 2'h1 : 2'h2; // [R13]

    // ---------------------------------------------------------------
    // Enable / supply edges
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            enable_d_reg <= 1'b0;
            supply_d_reg <= 1'b0;
        end else begin
            enable_d_reg <= enable;
            supply_d_reg <= supply_ok;
        end
    end
    assign rearm = (enable && !enable_d_reg) || (supply_ok && !supply_d_reg); // [R5] [R23]
    assign run_en = enable && supply_ok && (input_feedforward_ok || !enable); // [R14]

    // ---------------------------------------------------------------
    // Over-current latch-off counter
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset || !over_limit || state_reg == ST_FAULT) begin
            oc_cnt_reg <= '0; // [R6]
        end else if (oc_cnt_reg < 32'(OC_CYCLES)) begin
            oc_cnt_reg <= oc_cnt_reg + 32'h1; // [R3]
        end
    end
    assign oc_trip = over_limit_150 || (over_limit && oc_cnt_reg >= 32'(OC_CYCLES) - 32'h1); // [R3] [R4]

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg   <= ST_CONFIG;
            cfg_cnt_reg <= '0;
            ov_reg      <= 1'b0;
        end else begin
            case (state_reg)
                ST_CONFIG: begin
                    cfg_cnt_reg <= cfg_cnt_reg + 16'h1;
                    if (cfg_cnt_reg == 16'(CONFIG_CYCLES - 1)) begin
                        state_reg <= ST_WAIT_EN; // [R17]
                    end
                end
                ST_WAIT_EN: begin
                    if (run_en) begin
                        state_reg <= ST_MID; // [R18]
                    end
                end
                ST_MID: begin
                    if (!run_en) begin
                        state_reg <= ST_WAIT_EN;
                    end else if (driver_on_handshake_in) begin
                        state_reg <= ST_RAMP; // [R15]
                    end
                end
                ST_RAMP, ST_RUN: begin
                    if (over_voltage || oc_trip) begin
                        state_reg <= ST_FAULT;
                        ov_reg    <= over_voltage; // [R21]
                    end else if (!run_en || !driver_on_handshake_in) begin
                        state_reg <= ST_WAIT_EN; // [R20]
                    end else if (state_reg == ST_RAMP && dac_code == target_code) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_FAULT: begin
                    if (rearm) begin
                        state_reg <= ST_WAIT_EN; // [R5] [R23]
                        ov_reg    <= 1'b0;
                    end
                end
                default: state_reg <= ST_CONFIG;
            endcase
        end
    end
    assign fault_latched       = (state_reg == ST_FAULT);
    assign driver_on_handshake = (state_reg == ST_RAMP) || (state_reg == ST_RUN)
                                 || (fault_latched && ov_reg); // [R18] [R22]
    assign regulator_ready     = (state_reg == ST_RUN); // [R21]

    // ---------------------------------------------------------------
    // Soft-start DAC
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dac_code     <= '0;
            step_cnt_reg <= '0;
        end else if (state_reg == ST_RAMP || (fault_latched && ov_reg)) begin
            step_cnt_reg <= (step_cnt_reg == 16'(SS_STEP_CYCLES - 1)) ? 16'h0 : step_cnt_reg + 16'h1;
            if (step_cnt_reg == 16'(SS_STEP_CYCLES - 1)) begin
                if (fault_latched) begin
                    dac_code <= (dac_code != '0) ? dac_code - 8'h1 : dac_code; // [R21]
                end else if (dac_code < target_code) begin
                    dac_code <= dac_code + 8'h1; // [R16]
                end
            end
        end else if (state_reg != ST_RUN) begin
            dac_code     <= '0;
            step_cnt_reg <= '0;
        end
    end

    // ---------------------------------------------------------------
    // Drive outputs
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset || !(state_reg == ST_RAMP || state_reg == ST_RUN)) begin
            core_fired_reg <= '0; // [R20]
            aux_fired_reg  <= '0;
        end else begin
            core_fired_reg <= core_fired_reg | (core_pwm_req & core_en); // [R19]
            aux_fired_reg  <= aux_fired_reg | (aux_pwm_req & aux_en);
        end
    end

    function automatic drive_e drive_level(input logic en, input logic fired, input logic req);
        drive_e lvl;
        lvl = DRV_MID;
        if (!en || state_reg == ST_CONFIG) begin
            lvl = DRV_FLOAT; // [R17]
        end else if (state_reg == ST_FAULT) begin
            lvl = ov_reg ? DRV_LOW : DRV_FLOAT; // [R22]
        end else if (state_reg == ST_WAIT_EN) begin
            lvl = supply_ok ? DRV_MID : DRV_FLOAT; // [R20]
        end else if (fired || req) begin
            lvl = req ? DRV_HIGH : DRV_LOW; // [R19]
        end
        return lvl;
    endfunction

    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase1_drive_out     <= DRV_FLOAT;
            phase2_drive_out     <= DRV_FLOAT;
            phase3_drive_out     <= DRV_FLOAT;
            phase4_drive_out     <= DRV_FLOAT;
            aux_phase1_drive_out <= DRV_FLOAT;
            aux_phase2_drive_out <= DRV_FLOAT;
        end else begin
            phase1_drive_out     <= drive_level(core_en[0], core_fired_reg[0], core_pwm_req[0]); // [R18]
            phase2_drive_out     <= drive_level(core_en[1], core_fired_reg[1], core_pwm_req[1]);
            phase3_drive_out     <= drive_level(core_en[2], core_fired_reg[2], core_pwm_req[2]);
            phase4_drive_out     <= drive_level(core_en[3], core_fired_reg[3], core_pwm_req[3]);
            aux_phase1_drive_out <= drive_level(aux_en[0], aux_fired_reg[0], aux_pwm_req[0]); // [R2]
            aux_phase2_drive_out <= drive_level(aux_en[1], aux_fired_reg[1], aux_pwm_req[1]);
        end
    end

    // ---------------------------------------------------------------
    // Converter captures and register reads
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            max_current_reg <= REG_RESET;
            captured_reg    <= 1'b0;
        end else if (!captured_reg && enable && state_reg != ST_CONFIG) begin
            // Code is volts scaled so 2.5 V gives 255, i.e. 1 A per step
            max_current_reg <= max_current_program_input; // [R7] [R8]
            captured_reg    <= 1'b1; // [R9]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            iout_reg     <= REG_RESET;
            temp_reg     <= REG_RESET;
            temp_cnt_reg <= '0;
        end else begin
            // Clamp: anything above 2.5 V reads as full current
            iout_reg <= (output_current_sample > ADC_FULL_SCALE) ? ADC_FULL_SCALE
                                                                 : output_current_sample; // [R10]
            temp_cnt_reg <= (temp_cnt_reg == 16'(TEMP_SAMPLE_CYCLES - 1)) ? 16'h0 : temp_cnt_reg + 16'h1;
            if (temp_cnt_reg == 16'(TEMP_SAMPLE_CYCLES - 1)) begin
                temp_reg <= temperature_sense_input; // [R11]
            end
        end
    end

    always_comb begin
        // No write path exists; the max-current register cannot be changed
        if (reg_addr == PLATFORM_MAX_CURRENT_OFS) begin
            reg_rdata = max_current_reg; // [R9]
        end else if (reg_addr == OUTPUT_CURRENT_OFS) begin
            reg_rdata = iout_reg;
        end else if (reg_addr == TEMP_READING_OFS) begin
            reg_rdata = temp_reg;
        end else begin
            reg_rdata = 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence ov_hit_s;
        (state_reg == ST_RAMP || state_reg == ST_RUN) && over_voltage;
    endsequence
    sequence ov_latched_s;
        fault_latched && ov_reg && !regulator_ready;
    endsequence
    chk_ov_latch_entry: assert property (ov_hit_s |=> ov_latched_s) else $error("ov fault not latched"); // [R21]
    chk_ov_low_sides: assert property (ov_latched_s |=> phase1_drive_out == DRV_LOW) else $error("ov drive"); // [R22]
    chk_fault_held: assert property (fault_latched && !rearm |=> fault_latched) else $error("fault left"); // [R5] [R23]
    chk_oc_count_clear: assert property (!over_limit |=> oc_cnt_reg == 32'h0) else $error("oc count kept"); // [R6]
    chk_oc150_trip: assert property (state_reg == ST_RUN && over_limit_150 |=> fault_latched) else $error("oc150"); // [R4]
    chk_start_hold_off: assert property (state_reg == ST_MID && !driver_on_handshake_in |=> state_reg != ST_RAMP)
        else $error("start without handshake"); // [R15]
    chk_config_float: assert property (state_reg == ST_CONFIG |=> phase1_drive_out == DRV_FLOAT)
        else $error("drive not floating in config"); // [R17]
endmodule

// *** sim/gate_driver_model.sv ***
`timescale 1ns/10ps
module gate_driver_model #(
    parameter int HOLD_CYCLES = 16
) (
    // Clock
    input  wire logic core_clk,
    // Driver supply state set by the bench
    input  wire logic supply_low,
    // Handshake back to the controller
    output logic      driver_on_handshake_in
);
    // ----
    // Driver supply lockout
    // ----
    int hold_reg = HOLD_CYCLES;

    // Minimum low time restarts whenever supply sags
    always @(posedge core_clk) begin
        if (supply_low) begin
            hold_reg <= HOLD_CYCLES;
        end else if (hold_reg > 0) begin
            hold_reg <= hold_reg - 1;
        end
    end

    assign driver_on_handshake_in = (hold_reg == 0);
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import seq_pkg::*;
    localparam int OC = 20;
    logic core_clk = 0, reset = 1, supply_ok = 1, enable = 0, input_feedforward_ok = 1, supply_low = 1;
    logic phase2_sense_strap = 0, phase3_sense_strap = 0, phase4_sense_strap = 0;
    logic aux_phase1_sense_strap = 0, aux_phase2_sense_strap = 0;
    logic over_limit = 0, over_limit_150 = 0, over_voltage = 0;
    logic [3:0] phase4_freq_strap = 4'h0, core_pwm_req = 4'h0, freq_select;
    logic [7:0] max_current_program_input = 8'h00, output_current_sample = 8'h00;
    logic [7:0] temperature_sense_input = 8'h00, target_code = 8'h01, reg_addr = 8'h00;
    logic [7:0] dac_code, reg_rdata, v, d;
    logic [2:0] core_phase_count, sv, cnt;
    logic [1:0] core_ramp_step, aux_pwm_req = 2'h0;
    logic       driver_on_handshake_in, driver_on_handshake, regulator_ready, fault_latched;
    drive_e     phase1_drive_out, phase2_drive_out, phase3_drive_out, phase4_drive_out;
    drive_e     aux_phase1_drive_out, aux_phase2_drive_out;
    logic [2:0] tbl [4] = '{3'b000, 3'b001, 3'b101, 3'b111};
    int         failures = 0, cmp_count = 0, cycles = 0, i, k;

    multiphase_startup_fault_sequencer #(.OC_CYCLES(OC)) dut_u (
        .core_clk(core_clk), .reset(reset), .supply_ok(supply_ok), .enable(enable),
        .input_feedforward_ok(input_feedforward_ok), .phase2_sense_strap(phase2_sense_strap),
        .phase3_sense_strap(phase3_sense_strap), .phase4_sense_strap(phase4_sense_strap),
        .aux_phase1_sense_strap(aux_phase1_sense_strap), .aux_phase2_sense_strap(aux_phase2_sense_strap),
        .phase4_freq_strap(phase4_freq_strap), .over_limit(over_limit), .over_limit_150(over_limit_150),
        .over_voltage(over_voltage), .max_current_program_input(max_current_program_input),
        .output_current_sample(output_current_sample), .temperature_sense_input(temperature_sense_input),
        .target_code(target_code), .core_pwm_req(core_pwm_req), .aux_pwm_req(aux_pwm_req),
        .driver_on_handshake_in(driver_on_handshake_in), .driver_on_handshake(driver_on_handshake),
        .phase1_drive_out(phase1_drive_out), .phase2_drive_out(phase2_drive_out),
        .phase3_drive_out(phase3_drive_out), .phase4_drive_out(phase4_drive_out),
        .aux_phase1_drive_out(aux_phase1_drive_out), .aux_phase2_drive_out(aux_phase2_drive_out),
        .core_phase_count(core_phase_count), .freq_select(freq_select), .core_ramp_step(core_ramp_step),
        .regulator_ready(regulator_ready), .dac_code(dac_code), .fault_latched(fault_latched),
        .reg_addr(reg_addr), .reg_rdata(reg_rdata));
    gate_driver_model #(.HOLD_CYCLES(16)) drv_u (.core_clk(core_clk), .supply_low(supply_low),
        .driver_on_handshake_in(driver_on_handshake_in));

    // ----
    // Clock, watchdog, helpers
    // ----
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    function automatic logic [2:0] exp_count(input logic [2:0] s);
        casez (s)
            3'b111: return 3'h1;
            3'b101: return 3'h2;
            3'b??1: return 3'h3;
            default: return 3'h4;
        endcase
    endfunction

    task automatic do_reset();
        @(posedge core_clk);
        reset <= 1'b1;
        enable <= 1'b0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        tick(2);
        check("cfg_float", phase1_drive_out, DRV_FLOAT);
        tick(CONFIG_CYCLES + 4);
    endtask

    // Bound covers a restarted configuration plus the longest ramp
    task automatic bring_up();
        @(posedge core_clk);
        enable <= 1'b1;
        for (i = 0; i < 1000 && regulator_ready !== 1'b1; i++) tick(1);
        check("ready", regulator_ready, 1'b1);
        check("dac_top", dac_code, target_code);
        check("driver_on_handshake_on", driver_on_handshake, 1'b1);
    endtask

    // ----
    // Sequence
    // ----
    initial begin
        void'($urandom(26));
        for (k = 0; k < 5; k++) begin
            sv = (k < 4) ? tbl[k] : 3'($urandom);
            cnt = exp_count(sv);
            @(posedge core_clk);
            {phase2_sense_strap, phase3_sense_strap, phase4_sense_strap} <= sv;
            {aux_phase2_sense_strap, aux_phase1_sense_strap} <= 2'(k);
            phase4_freq_strap <= 4'($urandom);
            do_reset();
            check("count", core_phase_count, cnt);
            check("freq", freq_select, phase4_freq_strap);
            check("step", core_ramp_step, (cnt == 3'h4) ? 2'h1 : 2'h2);
            @(posedge core_clk);
            enable <= 1'b1;
            tick(8);
            check("p1_mid", phase1_drive_out, DRV_MID);
            check("p2", phase2_drive_out, (cnt >= 3'h3) ? DRV_MID : DRV_FLOAT);
            check("p3", phase3_drive_out, (cnt >= 3'h2) ? DRV_MID : DRV_FLOAT);
            check("p4", phase4_drive_out, (cnt == 3'h4) ? DRV_MID : DRV_FLOAT);
            check("a1", aux_phase1_drive_out, k[0] ? DRV_FLOAT : DRV_MID);
            check("a2", aux_phase2_drive_out, k[1] ? DRV_FLOAT : DRV_MID);
            check("hold_off", {driver_on_handshake, regulator_ready}, 2'h0);
        end
        @(posedge core_clk);
        {phase2_sense_strap, phase3_sense_strap, phase4_sense_strap} <= 3'h0;
        {aux_phase2_sense_strap, aux_phase1_sense_strap} <= 2'h0;
        target_code <= 8'($urandom_range(4, 1));
        v = 8'($urandom);
        max_current_program_input <= v;
        reg_addr <= PLATFORM_MAX_CURRENT_OFS;
        do_reset();
        check("max_current_program_input_rst", reg_rdata, REG_RESET);
        @(posedge core_clk);
        supply_low <= 1'b0;
        bring_up();
        @(posedge core_clk);
        max_current_program_input <= ~v;
        tick(3);
        check("max_current_program_input", reg_rdata, v);
        check("p2_wait", phase2_drive_out, DRV_MID);
        @(posedge core_clk);
        core_pwm_req <= 4'h2;
        aux_pwm_req <= 2'h1;
        @(posedge core_clk);
        core_pwm_req <= 4'h0;
        aux_pwm_req <= 2'h0;
        tick(3);
        check("a1_left", aux_phase1_drive_out, DRV_LOW);
        check("a2_stay", aux_phase2_drive_out, DRV_MID);
        check("p2_left", phase2_drive_out === DRV_MID, 1'b0);
        check("p3_stay", phase3_drive_out, DRV_MID);
        @(posedge core_clk);
        output_current_sample <= 8'($urandom);
        temperature_sense_input <= 8'($urandom);
        reg_addr <= OUTPUT_CURRENT_OFS;
        tick(3);
        check("iout", reg_rdata, output_current_sample);
        tick(TEMP_SAMPLE_CYCLES + 4);
        @(posedge core_clk);
        reg_addr <= TEMP_READING_OFS;
        tick(2);
        check("temp", reg_rdata, temperature_sense_input);
        @(posedge core_clk);
        reg_addr <= 8'h40;
        enable <= 1'b0;
        tick(3);
        check("unmapped", reg_rdata, 8'h00);
        check("dis_mid", phase2_drive_out, DRV_MID);
        check("dis_rdy", regulator_ready, 1'b0);
        @(posedge core_clk);
        input_feedforward_ok <= 1'b0;
        tick(10);
        check("ff_ign", fault_latched, 1'b0);
        @(posedge core_clk);
        enable <= 1'b1;
        tick(40);
        check("ff_block", driver_on_handshake, 1'b0);
        @(posedge core_clk);
        input_feedforward_ok <= 1'b1;
        bring_up();
        // Short over-limit must leave no trace
        @(posedge core_clk);
        over_limit <= 1'b1;
        tick(OC - 4);
        @(posedge core_clk);
        over_limit <= 1'b0;
        tick(3);
        check("oc_short", fault_latched, 1'b0);
        @(posedge core_clk);
        over_limit <= 1'b1;
        tick(OC - 4);
        check("oc_early", fault_latched, 1'b0);
        tick(8);
        check("oc_trip", fault_latched, 1'b1);
        check("oc_float", phase1_drive_out, DRV_FLOAT);
        @(posedge core_clk);
        over_limit <= 1'b0;
        tick(10);
        check("oc_hold", fault_latched, 1'b1);
        @(posedge core_clk);
        enable <= 1'b0;
        tick(3);
        bring_up();
        @(posedge core_clk);
        over_limit_150 <= 1'b1;
        tick(3);
        check("oc150", fault_latched, 1'b1);
        @(posedge core_clk);
        over_limit_150 <= 1'b0;
        supply_ok <= 1'b0;
        tick(3);
        @(posedge core_clk);
        supply_ok <= 1'b1;
        bring_up();
        @(posedge core_clk);
        over_voltage <= 1'b1;
        @(posedge core_clk);
        over_voltage <= 1'b0;
        tick(3);
        d = dac_code;
        check("ov_flag", {fault_latched, regulator_ready}, 2'h2);
        check("ov_low", {phase1_drive_out, phase2_drive_out, phase3_drive_out, phase4_drive_out}, 8'h55);
        tick(140);
        check("ov_down", dac_code < d, 1'b1);
        for (i = 0; i < 400 && dac_code !== 8'h00; i++) tick(1);
        check("ov_zero", dac_code, 8'h00);
        tick(20);
        check("ov_latch", fault_latched, 1'b1);
        @(posedge core_clk);
        enable <= 1'b0;
        tick(3);
        bring_up();
        conclude();
    end
endmodule
